// ===== hw/subghz_cfg_pkg.sv
// Shared constants and types for the transmitter configuration port.
// Assumes a 40 MHz ref_clk; all pin timing is counted in ref_clk cycles.
package subghz_cfg_pkg;

	// Frame layout
	localparam int FRAME_BITS = 24;
	localparam int CMD_BITS = 8;
	localparam int DATA_BITS = 16;
	localparam int FREQ_BITS = 19;
	localparam logic [4:0] LAST_EDGE = 5'h17;
	localparam logic [4:0] CMD_EDGE = 5'h07;

	// Command codes
	localparam logic [7:0] CMD_WR_APP = 8'h00;
	localparam logic [7:0] CMD_RD_APP = 8'h33;
	localparam logic [7:0] CMD_RD_FREQ = 8'h44;
	localparam logic [7:0] CMD_RD_STAT = 8'h55;
	localparam logic [4:0] PFX_WR_FREQ = 5'h03;

	// Application settings layout, bit 15 down to bit 0
	typedef struct packed {
		logic manual_mode;
		logic ook_mode;
		logic band_upper;
		logic [7:0] fsk_deviation;
		logic power_high;
		logic long_off;
		logic [2:0] fixed_bits;
	} app_t;

	// Power-on presets, chosen by the select line level
	localparam logic [15:0] APP_PRESET_LO = 16'h201c;
	localparam logic [15:0] APP_PRESET_HI = 16'h40d4;
	localparam logic [18:0] FREQ_PRESET_LO = 19'h42c1c;
	localparam logic [18:0] FREQ_PRESET_HI = 19'h42cad;

	// Version and state flag field, and strap settle count
	localparam int READY_FLAG_BIT = 1;
	localparam logic [2:0] STRAP_SETTLE = 3'h4;

	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int WAKE_TIME_NS = 100000;
	localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 20;

	// Pin pair carried through the synchroniser
	typedef struct packed {
		logic sel_clk;
		logic data;
	} pins_t;

	typedef enum logic [1:0] {
		ST_STRAP = 2'b00,
		ST_SLEEP = 2'b01,
		ST_TX = 2'b10
	} tx_state_t;

endpackage

// ===== hw/pin_sync3.sv
// Three-flop synchroniser with agreement filter.
// Assumes inputs are asynchronous pins; output changes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync3 import subghz_cfg_pkg::*; #(
	parameter int W = 2
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] agree;
	logic [W-1:0] level_d;

	assign agree = ~(s2_q ^ s3_q);
	assign level_d = (agree & s3_q) | (~agree & level_q);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			level_q <= '0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
		end
	end
endmodule // pin_sync3

// ===== hw/hold_timer.sv
// Counts cycles while run is high; done once the count reaches limit.
// Assumes run drops to restart the count.
`timescale 1ns/1ps
module hold_timer import subghz_cfg_pkg::*; #(
	parameter int W = TMR_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [W-1:0] limit,
	output logic done
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic at_limit;

	assign at_limit = (cnt_q >= limit);
	assign cnt_d = !run ? '0 : (at_limit ? cnt_q : cnt_q + 1'b1);
	assign done = run && at_limit;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // hold_timer

// ===== hw/subghz_tx_config_port.sv
// Configuration, readback and keying logic of the sub-GHz transmitter.
// Assumes sel_clk_pin and data_pin_in come straight from pins; the analog
// synthesizer and amplifier take the keying outputs.
//
// Behaviour
// - At power-on sample select line level, load one of two preset sets.
// - After power-on, data line low puts transmitter to sleep.
// - Data line is captured on each rising edge of select line.
// - A frame is exactly 24 rising edges; only then does it take effect.
// - A cut-short frame is recovered by a dedicated idle pattern.
// - Command zero writes application bits; 0x33 reads them back.
// - Command 0x55 returns version, state flags, top three frequency bits.
// - Application bit 15 selects automatic or manual mode, preset zero.
// - Application bit 14 selects FSK or OOK, preset by select level.
// - Application bit 13 selects lower or upper band, preset by select level.
// - Application bits 12 to 5 hold FSK deviation, preset 0x06 when high.
// - Bit 4 selects output power, bit 3 the auto-off time.
// - Exactly three registers: application, frequency, version and flags.
// - After configuration, data line is the transmit bit stream.
// - OOK keys the power amplifier; FSK shifts synthesizer frequency.
// - Transmit starts after data line stays high beyond the wake time.
// - Automatic mode sleeps after data low beyond auto-off time.
// - Manual mode transmits continuously until the mode bit clears.
`timescale 1ns/1ps
module subghz_tx_config_port import subghz_cfg_pkg::*; #(
	parameter int OFF_SHORT_US = 2000,
	parameter int OFF_LONG_US = 20000,
	parameter int RECOVER_US = 500,
	parameter logic [7:0] DEV_PRESET_LO = 8'h00,
	// Arbitrary version value
	parameter logic [7:0] VERSION_FIELD = 8'h5a
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sel_clk_pin,
	input wire logic data_pin_in,
	output logic data_pin_out,
	output logic data_pin_oe,
	output app_t app_setting_bits,
	output logic [FREQ_BITS-1:0] tx_freq_word,
	output logic tx_active,
	output logic power_amplifier,
	output logic fsk_upper
);
	localparam int OFF_SHORT_CYC = (OFF_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OFF_LONG_CYC = (OFF_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYC = (RECOVER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [TMR_W-1:0] OFF_SHORT_LIM = TMR_W'(OFF_SHORT_CYC);
	localparam logic [TMR_W-1:0] OFF_LONG_LIM = TMR_W'(OFF_LONG_CYC);
	localparam logic [TMR_W-1:0] RECOVER_LIM = TMR_W'(RECOVER_CYC);
	localparam logic [TMR_W-1:0] WAKE_LIM = TMR_W'(WAKE_CYCLES);

	// Synchronised pins
	pins_t pins;
	logic prev_clk_q;
	logic clk_rise;

	// Start-up strap
	tx_state_t state_q;
	tx_state_t state_d;
	logic [2:0] settle_q;
	logic strap_load;

	// Serial framing
	logic [4:0] edge_cnt_q;
	logic [FRAME_BITS-2:0] shift_q;
	logic [FRAME_BITS-1:0] word_in;
	logic [CMD_BITS-1:0] cmd_in;
	logic [DATA_BITS-1:0] rd_shift_q;
	logic [DATA_BITS-1:0] rd_sel;
	logic is_read_cmd;
	logic at_cmd_edge;
	logic at_last_edge;
	logic in_read_data;
	logic frame_idle;
	logic recover_run;
	logic recover_done;

	// Register writes
	logic wr_app;
	logic wr_freq;
	app_t app_d;
	logic [FREQ_BITS-1:0] freq_d;
	logic [DATA_BITS-1:0] stat_word;

	// Transmit control
	logic wake_run;
	logic wake_done;
	logic off_run;
	logic off_done;
	logic [TMR_W-1:0] off_lim;
	logic keying_on;
	logic pa_d;
	logic fsk_d;

	pin_sync3 #(
		.W(2)
	) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pin_in({sel_clk_pin, data_pin_in}),
		.level_q(pins)
	);

	// Edge finding on the filtered select line
	assign clk_rise = pins.sel_clk & ~prev_clk_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prev_clk_q <= 1'b0;
		end else begin
			prev_clk_q <= pins.sel_clk;
		end
	end

	// Presets load once the synchroniser has settled after reset
	assign strap_load = (state_q == ST_STRAP) && (settle_q == STRAP_SETTLE);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			settle_q <= 3'h0;
		end else if (state_q == ST_STRAP) begin
			settle_q <= settle_q + 3'h1;
		end
	end

	// Frame decode
	assign word_in = {shift_q, pins.data};
	assign cmd_in = word_in[CMD_BITS-1:0];
	assign at_cmd_edge = clk_rise && (edge_cnt_q == CMD_EDGE);
	assign at_last_edge = clk_rise && (edge_cnt_q == LAST_EDGE);
	assign in_read_data = clk_rise && data_pin_oe && !at_cmd_edge && !at_last_edge;
	assign is_read_cmd = (cmd_in == CMD_RD_APP) || (cmd_in == CMD_RD_FREQ)
		|| (cmd_in == CMD_RD_STAT);
	assign frame_idle = (edge_cnt_q == 5'h00);

	// Read sources
	assign stat_word = {VERSION_FIELD, 3'h0, tx_active, 1'b0,
		tx_freq_word[FREQ_BITS-1:DATA_BITS]};
	assign rd_sel = (cmd_in == CMD_RD_APP) ? app_setting_bits :
		(cmd_in == CMD_RD_FREQ) ? tx_freq_word[DATA_BITS-1:0] :
		stat_word;

	// Writes commit only on the last edge of a whole frame
	assign wr_app = at_last_edge && (word_in[FRAME_BITS-1 -: CMD_BITS] == CMD_WR_APP);
	assign wr_freq = at_last_edge && (word_in[FRAME_BITS-1 -: 5] == PFX_WR_FREQ);

	// Stalled frame recovery: both lines idle low mid-frame
	assign recover_run = !frame_idle && !pins.sel_clk && !pins.data;

	hold_timer #(
		.W(TMR_W)
	) u_recover (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(recover_run),
		.limit(RECOVER_LIM),
		.done(recover_done)
	);

	// Serial shift and edge count, MSB first
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			edge_cnt_q <= 5'h00;
			shift_q <= '0;
		end else if (state_q == ST_STRAP) begin
			edge_cnt_q <= 5'h00;
		end else if (recover_done) begin
			edge_cnt_q <= 5'h00;
		end else if (at_last_edge) begin
			edge_cnt_q <= 5'h00;
		end else if (clk_rise) begin
			edge_cnt_q <= edge_cnt_q + 5'h01;
			shift_q <= word_in[FRAME_BITS-2:0];
		end
	end

	// Read data drive: first bit after the command edge, then one per edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_shift_q <= '0;
			data_pin_out <= 1'b0;
			data_pin_oe <= 1'b0;
		end else if (recover_done || at_last_edge) begin
			data_pin_oe <= 1'b0;
			data_pin_out <= 1'b0;
		end else if (at_cmd_edge && is_read_cmd) begin
			rd_shift_q <= {rd_sel[DATA_BITS-2:0], 1'b0};
			data_pin_out <= rd_sel[DATA_BITS-1];
			data_pin_oe <= 1'b1;
		end else if (in_read_data) begin
			rd_shift_q <= {rd_shift_q[DATA_BITS-2:0], 1'b0};
			data_pin_out <= rd_shift_q[DATA_BITS-1];
		end
	end

	// Register file: application and frequency words
	assign app_d = strap_load ? (pins.sel_clk ? app_t'(APP_PRESET_HI) :
		app_t'({APP_PRESET_LO[15:13], DEV_PRESET_LO, APP_PRESET_LO[4:0]})) :
		wr_app ? app_t'(word_in[DATA_BITS-1:0]) : app_setting_bits;
	assign freq_d = strap_load ? (pins.sel_clk ? FREQ_PRESET_HI : FREQ_PRESET_LO) :
		wr_freq ? word_in[FREQ_BITS-1:0] : tx_freq_word;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			app_setting_bits <= '0;
			tx_freq_word <= '0;
		end else begin
			app_setting_bits <= app_d;
			tx_freq_word <= freq_d;
		end
	end

	// Wake: data high with no frame activity for the wake time
	assign wake_run = (state_q == ST_SLEEP) && pins.data && frame_idle && !clk_rise;

	hold_timer #(
		.W(TMR_W)
	) u_wake (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(wake_run),
		.limit(WAKE_LIM),
		.done(wake_done)
	);

	// Auto-off: data low for the selected time, automatic mode only
	assign off_lim = app_setting_bits.long_off ? OFF_LONG_LIM : OFF_SHORT_LIM;
	assign off_run = (state_q == ST_TX) && !pins.data
		&& !app_setting_bits.manual_mode;

	hold_timer #(
		.W(TMR_W)
	) u_off (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(off_run),
		.limit(off_lim),
		.done(off_done)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_STRAP: begin
				if (strap_load) begin
					state_d = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake_done) begin
					state_d = ST_TX;
				end
			end
			ST_TX: begin
				if (off_done) begin
					state_d = ST_SLEEP;
				end
			end
			default: begin
				state_d = ST_STRAP;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_STRAP;
		end else begin
			state_q <= state_d;
		end
	end

	// Keying: data line is the transmit stream while active
	assign keying_on = (state_d == ST_TX);
	assign pa_d = keying_on && (!app_setting_bits.ook_mode || pins.data);
	assign fsk_d = keying_on && !app_setting_bits.ook_mode && pins.data;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_active <= 1'b0;
			power_amplifier <= 1'b0;
			fsk_upper <= 1'b0;
		end else begin
			tx_active <= keying_on;
			power_amplifier <= pa_d;
			fsk_upper <= fsk_d;
		end
	end

endmodule // subghz_tx_config_port

// ===== tb/subghz_tx_config_port_checker.sv
// Assertions on the configuration port's pins and outputs.
// Assumes the bind at the foot; one clock domain, reset active high.
`timescale 1ns/1ps
module subghz_tx_config_port_checker import subghz_cfg_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sel_clk_pin,
	input wire logic data_pin_in,
	input wire logic data_pin_oe,
	input wire app_t app_setting_bits,
	input wire logic [FREQ_BITS-1:0] tx_freq_word,
	input wire logic tx_active,
	input wire logic power_amplifier,
	input wire logic fsk_upper
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [12:0] hi_cnt_q;
	// Cycles the data pin has stayed high
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) hi_cnt_q <= '0;
		else if (!data_pin_in) hi_cnt_q <= '0;
		else if (hi_cnt_q != 13'h1fff) hi_cnt_q <= hi_cnt_q + 13'h1;
	end
	a_wake_hold_time: assert property ($rose(tx_active) |-> hi_cnt_q >= 13'd4000)
		else $error("transmit started early");
	a_sleep_quiet: assert property (!tx_active [*3] |-> !power_amplifier && !fsk_upper)
		else $error("keying while asleep");
	a_fsk_amp_on: assert property ((tx_active && !app_setting_bits.ook_mode) [*3]
		|-> power_amplifier)
		else $error("amplifier off in fsk");
	a_ook_amp_off: assert property ((tx_active && app_setting_bits.ook_mode && !data_pin_in) [*8]
		|-> !power_amplifier)
		else $error("amplifier on with data low");
	a_fsk_shift_data: assert property ((tx_active && !app_setting_bits.ook_mode && data_pin_in) [*8]
		|-> fsk_upper)
		else $error("no shift with data high");
	a_oe_after_edge: assert property ($rose(data_pin_oe) |-> $past(sel_clk_pin, 2))
		else $error("drive without clock edge");
	a_oe_holds_frame: assert property ($rose(data_pin_oe) |=> data_pin_oe [*8])
		else $error("read drive too short");
	a_regs_stable_read: assert property (data_pin_oe && $past(data_pin_oe)
		|-> $stable(app_setting_bits) && $stable(tx_freq_word))
		else $error("register changed in read");
	a_manual_no_sleep: assert property ($fell(tx_active)
		|-> !$past(app_setting_bits.manual_mode))
		else $error("manual mode slept");
endmodule // subghz_tx_config_port_checker

bind subghz_tx_config_port subghz_tx_config_port_checker CHK (.ref_clk(ref_clk), .rst(rst),
	.sel_clk_pin(sel_clk_pin), .data_pin_in(data_pin_in), .data_pin_oe(data_pin_oe),
	.app_setting_bits(app_setting_bits), .tx_freq_word(tx_freq_word), .tx_active(tx_active),
	.power_amplifier(power_amplifier), .fsk_upper(fsk_upper));

// ===== tb/host_mcu_model.sv
// Host microcontroller driving the select clock and the data line.
// Assumes the device drive wins the data line; a released line toggles each cycle.
`timescale 1ns/1ps
module host_mcu_model #(
	parameter int HALF = 4
) (
	input wire logic ref_clk,
	input wire logic data_pin_out,
	input wire logic data_pin_oe,
	output logic sel_clk_pin,
	output logic data_line
);
	logic drv_en = 1'b1;
	logic drv_val = 1'b0;
	logic last_q = 1'b0;
	initial sel_clk_pin = 1'b0;
	assign data_line = data_pin_oe ? data_pin_out : (drv_en ? drv_val : ~last_q);
	always @(posedge ref_clk) last_q <= data_line;
	task automatic pace(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Bits MSB first, reads release the line for the data phase
	// Application writes carry 100 in the three lowest bits
	task automatic frame(input logic [23:0] w, input int nb, output logic [15:0] rx);
		logic rd;
		rd = w[23:16] inside {8'h33, 8'h44, 8'h55};
		rx = '0;
		for (int i = 23; i >= 24 - nb; i--) begin
			drv_en <= !(rd && i < 16);
			drv_val <= w[i];
			sel_clk_pin <= 1'b0;
			pace(HALF);
			if (i < 16) rx[i] = data_line;
			sel_clk_pin <= 1'b1;
			pace(HALF);
		end
		idle(2 * HALF);
	endtask
	// Both lines low; a long idle recovers framing
	task automatic idle(input int n);
		sel_clk_pin <= 1'b0;
		drv_en <= 1'b1;
		drv_val <= 1'b0;
		pace(n);
	endtask
	// Select line level held steady from power-on
	task automatic strap(input logic lvl);
		sel_clk_pin <= lvl;
	endtask
	task automatic key(input logic v);
		drv_val <= v;
	endtask
endmodule // host_mcu_model

// ===== tb/subghz_tx_config_port_tb.sv
// Self-checking bench for the configuration port.
// Assumes short auto-off and recovery times set by parameter.
`timescale 1ns/1ps
module subghz_tx_config_port_tb;
	import subghz_cfg_pkg::*;
	localparam logic [7:0] VER = 8'h3c; // Arbitrary version value
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic sel_clk_pin, data_line, data_pin_out, data_pin_oe;
	logic tx_active, power_amplifier, fsk_upper;
	app_t app_setting_bits;
	logic [FREQ_BITS-1:0] tx_freq_word;
	logic [15:0] rx;
	int errors = 0;
	int compares = 0;
	always #12.5 ref_clk = ~ref_clk;
	host_mcu_model HOST (.ref_clk(ref_clk), .data_pin_out(data_pin_out),
		.data_pin_oe(data_pin_oe), .sel_clk_pin(sel_clk_pin), .data_line(data_line));
	subghz_tx_config_port #(.OFF_SHORT_US(2), .OFF_LONG_US(5), .RECOVER_US(2),
		.VERSION_FIELD(VER)) DUT (.ref_clk(ref_clk), .rst(rst), .sel_clk_pin(sel_clk_pin),
		.data_pin_in(data_line), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
		.app_setting_bits(app_setting_bits), .tx_freq_word(tx_freq_word),
		.tx_active(tx_active), .power_amplifier(power_amplifier), .fsk_upper(fsk_upper));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset(input logic lvl);
		HOST.strap(lvl);
		rst <= 1'b1;
		HOST.pace(16);
		rst <= 1'b0;
		HOST.pace(20);
	endtask
	task automatic test_presets();
		do_reset(1'b1);
		check({app_setting_bits[15:13], app_setting_bits[12:5], app_setting_bits[4:0]},
			{3'b010, 8'h06, 5'b10100});
		check(tx_freq_word, FREQ_PRESET_HI);
		do_reset(1'b0);
		check({app_setting_bits[15:13], app_setting_bits[4:0]}, 8'b001_11100);
		check(tx_freq_word, FREQ_PRESET_LO);
		check(tx_active, 1'b0);
	endtask
	task automatic test_regs();
		check(tx_active, 1'b0);
		HOST.frame({8'h00, 16'h5a3c}, 24, rx);
		check(app_setting_bits, 16'h5a3c);
		HOST.frame({8'h33, 16'h0000}, 24, rx);
		check(rx, 16'h5a3c);
		check(data_pin_oe, 1'b0);
		HOST.frame({5'h03, 19'h5a5c3}, 24, rx);
		check(tx_freq_word, 19'h5a5c3);
		HOST.frame({8'h44, 16'h0000}, 24, rx);
		check(rx, 16'ha5c3);
		HOST.frame({8'h55, 16'h0000}, 24, rx);
		check(rx, {VER, 5'b00000, 3'b101});
		HOST.frame({8'h77, 16'hffff}, 24, rx);
		check({app_setting_bits, tx_freq_word}, {16'h5a3c, 19'h5a5c3});
	endtask
	task automatic test_recovery();
		HOST.frame({8'h00, 16'h1234}, 10, rx);
		HOST.idle(150);
		check(app_setting_bits, 16'h5a3c);
		HOST.frame({8'h00, 16'h2f0c}, 24, rx);
		check(app_setting_bits, 16'h2f0c);
	endtask
	task automatic test_tx(input logic ook);
		HOST.frame({8'h00, 1'b0, ook, 1'b1, 8'h11, 5'b10100}, 24, rx);
		HOST.key(1'b1);
		HOST.pace(3900);
		check(tx_active, 1'b0);
		HOST.pace(300);
		check({tx_active, power_amplifier, fsk_upper}, {2'b11, !ook});
		HOST.key(1'b0);
		HOST.pace(40);
		check({tx_active, power_amplifier, fsk_upper}, {1'b1, !ook, 1'b0});
		HOST.pace(100);
		check(tx_active, 1'b0);
	endtask
	task automatic test_manual();
		HOST.frame({8'h00, 1'b1, 1'b0, 1'b1, 8'h11, 5'b10100}, 24, rx);
		HOST.key(1'b1);
		HOST.pace(4200);
		check(tx_active, 1'b1);
		HOST.key(1'b0);
		HOST.pace(300);
		check(tx_active, 1'b1);
		HOST.frame({8'h00, 1'b0, 1'b0, 1'b1, 8'h11, 5'b10100}, 24, rx);
		check(app_setting_bits.manual_mode, 1'b0);
		HOST.pace(150);
		check(tx_active, 1'b0);
	endtask
	initial begin
		test_presets();
		test_regs();
		test_recovery();
		test_tx(1'b0);
		test_tx(1'b1);
		test_manual();
		give_verdict();
	end
	initial begin
		#2000000;
		errors++;
		give_verdict();
	end
endmodule // subghz_tx_config_port_tb
